//--- fpc_pwm_core.sv
// Four-channel pwm core with prescaler, scalers, pair concatenation and port pin takeover.
// Assumes synchronous pin inputs and a master that never issues read and write together.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fpc_pwm_core
  import fpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic special_mode_flag,
  input wire logic [3:0] port_pin_in,
  output logic [3:0] port_pin_out,
  output logic [3:0] port_pin_oe
);
  // ==========================================================
  // functions
  function automatic logic pre_tick(input logic [6:0] c, input logic [2:0] f);
    logic [7:0] m;
    m = (8'h01 << f) - 8'h01;
    return (c & m[6:0]) == m[6:0];
  endfunction

  // returns {reload, dir, out, count}
  function automatic logic [18:0] pwm_step(input logic [15:0] c, input logic [15:0] p,
                                           input logic [15:0] d, input logic pol,
                                           input logic ctr, input logic dir, input logic wide);
    logic [15:0] mx;
    logic [15:0] nc;
    logic nd;
    logic rl;
    logic o;
    mx = wide ? 16'hFFFF : 16'h00FF;
    nc = c;
    nd = dir;
    rl = 1'b0;
    if (!ctr) begin
      nd = 1'b0;
      if (c >= p) begin
        nc = 16'h0000;
        rl = 1'b1;
      end else begin
        nc = c + 16'h0001;
      end
    end else if (!dir) begin
      if (c >= p) begin
        nd = (c != 16'h0000);
        rl = (c == 16'h0000);
        nc = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
      end else begin
        nc = c + 16'h0001;
      end
    end else if (c == 16'h0000) begin
      nd = 1'b0;
      rl = 1'b1;
      nc = (p == 16'h0000) ? 16'h0000 : 16'h0001;
    end else begin
      nc = c - 16'h0001;
    end
    if (d == mx) begin
      o = ~pol;
    end else if (d >= p) begin
      o = pol;
    end else begin
      o = (nc < d) ? pol : ~pol;
    end
    return {rl, nd, o, nc};
  endfunction

  // ==========================================================
  // registers and decode
  logic [7:0] clk_cfg;
  logic [7:0] pol_cfg;
  logic [3:0] en_cfg;
  logic [7:0] scale [2];
  logic mode_cfg;
  logic [3:0] dir_cfg;
  logic [3:0] port_cfg;
  logic [6:0] presc;
  logic [7:0] scl_cnt [2];
  logic [1:0] scl_half;
  logic [7:0] cnt [NCH];
  logic [7:0] per_buf [NCH];
  logic [7:0] per_act [NCH];
  logic [7:0] dty_buf [NCH];
  logic [7:0] dty_act [NCH];
  logic [3:0] cdir;
  logic [3:0] wave;
  logic [3:0] started;

  wire any_en = |en_cfg;
  wire center = mode_cfg;
  wire [1:0] concat = {clk_cfg[CLK_CU], clk_cfg[CLK_CL]};
  wire [1:0] base_tick;
  wire [1:0] s_tick;
  wire [1:0] wr_scl;
  wire [3:0] sel_tick;
  wire [3:0] lane_en;
  wire [3:0] adv;
  wire [3:0] ld;
  wire [3:0] wr_cnt;
  wire [3:0] wr_per;
  wire [3:0] wr_dty;
  wire [3:0] nxt_dir;
  wire [3:0] nxt_wave;
  wire [7:0] nxt_cnt [NCH];
  wire [7:0] nxt_per [NCH];
  wire [7:0] nxt_dty [NCH];
  wire [2:0] grp = addr[4:2];
  wire [1:0] idx = addr[1:0];
  wire wr_pres = wr_en && addr == A_PRES;

  // prescaler stops with every channel off
  assign base_tick[0] = any_en & pre_tick(presc, clk_cfg[CLK_A_LSB +: 3]);
  assign base_tick[1] = any_en & pre_tick(presc, clk_cfg[CLK_B_LSB +: 3]);
  assign wr_scl[0] = wr_en && addr == A_SCL0;
  assign wr_scl[1] = wr_en && addr == A_SCL1;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_scl
      // scaled clock: base divided by scale plus one, then halved
      assign s_tick[s] = base_tick[s] & (scl_cnt[s] == 8'h00) & scl_half[s];
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      wire take = en_cfg[c] & ~(concat[c / 2] & 1'(c % 2));
      // clock select: base clock of the pair or its scaled clock
      assign sel_tick[c] = pol_cfg[POL_SEL_LSB + c] ? s_tick[c / 2] : base_tick[c / 2];
      assign wr_cnt[c] = wr_en && addr == {G_CNT, 2'(c)};
      assign wr_per[c] = wr_en && addr == {G_PER, 2'(c)};
      assign wr_dty[c] = wr_en && addr == {G_DTY, 2'(c)};
      assign nxt_per[c] = wr_per[c] ? wr_data : per_buf[c];
      assign nxt_dty[c] = wr_dty[c] ? wr_data : dty_buf[c];
      // enabled channel owns the pin, except the odd channel of a joined pair; direction bit untouched
      assign port_pin_oe[c] = take | dir_cfg[c];
      assign port_pin_out[c] = take ? (started[c] ? wave[c] : pol_cfg[c]) : port_cfg[c];
    end
  endgenerate

  // ==========================================================
  // channel pairs: two 8-bit lanes or one 16-bit lane
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      localparam int H = 2 * p;
      localparam int L = 2 * p + 1;
      wire [18:0] r_h;
      wire [18:0] r_l;
      wire [18:0] r_w;
      // joined pair runs on the low channel's clock selection
      wire t_w = en_cfg[H] & sel_tick[L];
      wire ld_w = (t_w & r_w[18]) | wr_cnt[H] | wr_cnt[L];
      assign r_h = pwm_step({8'h00, cnt[H]}, {8'h00, per_act[H]}, {8'h00, dty_act[H]},
                            pol_cfg[H], center, cdir[H], 1'b0);
      assign r_l = pwm_step({8'h00, cnt[L]}, {8'h00, per_act[L]}, {8'h00, dty_act[L]},
                            pol_cfg[L], center, cdir[L], 1'b0);
      assign r_w = pwm_step({cnt[H], cnt[L]}, {per_act[H], per_act[L]}, {dty_act[H], dty_act[L]},
                            pol_cfg[H], center, cdir[H], 1'b1);
      assign lane_en[H] = en_cfg[H];
      assign lane_en[L] = concat[p] ? en_cfg[H] : en_cfg[L];
      assign adv[H] = concat[p] ? t_w : en_cfg[H] & sel_tick[H];
      assign adv[L] = concat[p] ? t_w : en_cfg[L] & sel_tick[L];
      assign ld[H] = concat[p] ? ld_w : (adv[H] & r_h[18]) | wr_cnt[H];
      assign ld[L] = concat[p] ? ld_w : (adv[L] & r_l[18]) | wr_cnt[L];
      assign nxt_cnt[H] = concat[p] ? r_w[15:8] : r_h[7:0];
      assign nxt_cnt[L] = concat[p] ? r_w[7:0] : r_l[7:0];
      assign nxt_dir[H] = concat[p] ? r_w[17] : r_h[17];
      assign nxt_dir[L] = r_l[17];
      assign nxt_wave[H] = concat[p] ? r_w[16] : r_h[16];
      assign nxt_wave[L] = r_l[16];
    end
  endgenerate

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_cfg <= RST_REG;
      pol_cfg <= RST_REG;
      en_cfg <= RST_REG[3:0];
      mode_cfg <= RST_REG[0];
      dir_cfg <= RST_REG[3:0];
      port_cfg <= RST_REG[3:0];
      scale[0] <= RST_REG;
      scale[1] <= RST_REG;
    end else begin
      if (wr_en && addr == A_CLK) clk_cfg <= wr_data;
      if (wr_en && addr == A_POL) pol_cfg <= wr_data;
      if (wr_en && addr == A_EN) en_cfg <= wr_data[3:0];
      if (wr_en && addr == A_MODE) mode_cfg <= wr_data[MODE_CTR];
      if (wr_en && addr == A_DIR) dir_cfg <= wr_data[3:0];
      if (wr_en && addr == A_PORT) port_cfg <= wr_data[3:0];
      if (wr_scl[0]) scale[0] <= wr_data;
      if (wr_scl[1]) scale[1] <= wr_data;
    end
  end

  // ==========================================================
  // prescale counter and scalers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc <= RST_PRES;
      scl_cnt[0] <= RST_REG;
      scl_cnt[1] <= RST_REG;
      scl_half <= 2'h0;
    end else begin
      if (wr_pres && special_mode_flag) begin
        presc <= wr_data[6:0];
      end else if (any_en) begin
        presc <= presc + 7'h01;
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_scl[i]) begin
          scl_cnt[i] <= wr_data;
        end else if (base_tick[i]) begin
          scl_cnt[i] <= (scl_cnt[i] == 8'h00) ? scale[i] : scl_cnt[i] - 8'h01;
          if (scl_cnt[i] == 8'h00) scl_half[i] <= ~scl_half[i];
        end
      end
    end
  end

  // ==========================================================
  // channel state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        cnt[i] <= RST_REG;
        per_buf[i] <= RST_PER;
        per_act[i] <= RST_PER;
        dty_buf[i] <= RST_DTY;
        dty_act[i] <= RST_DTY;
      end
      cdir <= 4'h0;
      wave <= 4'h0;
      started <= 4'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        per_buf[i] <= nxt_per[i];
        dty_buf[i] <= nxt_dty[i];
        // disabled lanes follow the buffer; enabled ones take it on rollover
        if (!lane_en[i] || ld[i]) begin
          per_act[i] <= nxt_per[i];
          dty_act[i] <= nxt_dty[i];
        end
        if (wr_cnt[i]) begin
          cnt[i] <= 8'h00;
          cdir[i] <= 1'b0;
        end else if (adv[i]) begin
          cnt[i] <= nxt_cnt[i];
          cdir[i] <= nxt_dir[i];
        end
        if (adv[i]) wave[i] <= nxt_wave[i];
        if (!lane_en[i]) begin
          started[i] <= 1'b0;
        end else if (adv[i]) begin
          started[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // read port
  wire [7:0] rd_val =
    (addr == A_CLK) ? clk_cfg :
    (addr == A_POL) ? pol_cfg :
    (addr == A_EN) ? {4'h0, en_cfg} :
    (addr == A_PRES) ? {1'b0, presc} :
    (addr == A_SCL0) ? scale[0] :
    (addr == A_SCL1) ? scale[1] :
    (addr == A_MODE) ? {7'h00, mode_cfg} :
    (addr == A_DIR) ? {4'h0, dir_cfg} :
    (addr == A_PORT) ? {4'h0, port_pin_in} :
    (grp == G_CNT) ? cnt[idx] :
    (grp == G_PER) ? per_buf[idx] :
    (grp == G_DTY) ? dty_buf[idx] : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_val : 8'h00;
    end
  end

  // ==========================================================
  // assertions
  property p_pres_locked;
    @(posedge clock) disable iff (!rst_n)
    (wr_pres && !special_mode_flag && !any_en) |=> presc == $past(presc);
  endproperty
  a_pres_locked: assert property (p_pres_locked) else $error("prescale took a locked write");

  property p_pres_load;
    @(posedge clock) disable iff (!rst_n)
    (wr_pres && special_mode_flag) |=> presc == $past(wr_data[6:0]);
  endproperty
  a_pres_load: assert property (p_pres_load) else $error("prescale special write lost");

  property p_pres_stop;
    @(posedge clock) disable iff (!rst_n)
    (!any_en && !wr_pres) |=> $stable(presc);
  endproperty
  a_pres_stop: assert property (p_pres_stop) else $error("prescale ran with all channels off");

  property p_cnt_clear;
    @(posedge clock) disable iff (!rst_n)
    wr_cnt[0] |=> cnt[0] == 8'h00;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");

  property p_per_direct;
    @(posedge clock) disable iff (!rst_n)
    (wr_per[0] && !lane_en[0]) |=> per_act[0] == $past(wr_data);
  endproperty
  a_per_direct: assert property (p_per_direct) else $error("disabled period write not direct");

  property p_per_held;
    @(posedge clock) disable iff (!rst_n)
    (wr_per[0] && lane_en[0] && !ld[0]) |=> per_act[0] == $past(per_act[0]);
  endproperty
  a_per_held: assert property (p_per_held) else $error("enabled period write not buffered");

  property p_pin_take;
    @(posedge clock) disable iff (!rst_n)
    (en_cfg[0] && !dir_cfg[0]) |-> port_pin_oe[0];
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("enabled channel pin not driven");

  property p_tick_a;
    @(posedge clock) disable iff (!rst_n)
    (any_en && clk_cfg[CLK_A_LSB +: 3] == 3'h0) |-> base_tick[0] ##1 (base_tick[0] || !any_en);
  endproperty
  a_tick_a: assert property (p_tick_a) else $error("undivided clock A missed a tick");

  property p_duty_full;
    @(posedge clock) disable iff (!rst_n)
    (adv[0] && !concat[0] && dty_act[0] == 8'hFF) |=> wave[0] == !$past(pol_cfg[0]);
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("all-ones duty not inverted");
endmodule

//--- fpc_pkg.sv
// Constants for the four-channel pwm core: register indices, field positions, reset values.
// Assumes a single bus clock and a plain index-addressed register port.
package fpc_pkg;
  localparam int NCH = 4;
  localparam logic [4:0] A_CLK = 5'h00;
  localparam logic [4:0] A_POL = 5'h01;
  localparam logic [4:0] A_EN = 5'h02;
  localparam logic [4:0] A_PRES = 5'h03;
  localparam logic [4:0] A_SCL0 = 5'h04;
  localparam logic [4:0] A_SCL1 = 5'h05;
  localparam logic [4:0] A_MODE = 5'h06;
  localparam logic [4:0] A_DIR = 5'h07;
  localparam logic [4:0] A_PORT = 5'h08;
  localparam logic [2:0] G_CNT = 3'h4;
  localparam logic [2:0] G_PER = 3'h5;
  localparam logic [2:0] G_DTY = 3'h6;
  localparam int CLK_CU = 7;
  localparam int CLK_CL = 6;
  localparam int CLK_A_LSB = 3;
  localparam int CLK_B_LSB = 0;
  localparam int POL_SEL_LSB = 4;
  localparam int MODE_CTR = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PER = 8'hFF;
  localparam logic [7:0] RST_DTY = 8'hFF;
  localparam logic [6:0] RST_PRES = 7'h00;
endpackage

//--- fpc_pin_load.sv
// Load on the four port pins: the core drives a pin while its enable is high, else the load does.
// Assumes the bench picks the level the outside load drives on undriven pins.
`timescale 1ns/1ps
module fpc_pin_load (
  input wire logic [3:0] port_pin_out,
  input wire logic [3:0] port_pin_oe,
  input wire logic [3:0] ext_level,
  output logic [3:0] port_pin_in
);
  // ==========================================
  // pin level
  // a pin the core has taken shows the core value, a released one the load value
  assign port_pin_in = (port_pin_out & port_pin_oe) | (ext_level & ~port_pin_oe);
endmodule

//--- tb_four_channel_pwm_clocking_core.sv
// Self-checking bench for the four-channel pwm core.
// Assumes the index-addressed register port and one 25 MHz clock.
`timescale 1ns/1ps
module tb_four_channel_pwm_clocking_core;
  import fpc_pkg::*;
  logic clock, rst_n, wr_en, rd_en, special_mode_flag, meas;
  logic [4:0] addr;
  logic [7:0] wr_data, rd_data, v, w;
  logic [3:0] port_pin_in, port_pin_out, port_pin_oe, ext_level, dv, pd;
  integer seed = 32'h87ef_cdc9;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int hi_cnt = 0;
  int msel = 0;
  fpc_pwm_core i_fpc_pwm_core (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .special_mode_flag(special_mode_flag), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
  fpc_pin_load i_fpc_pin_load (.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .ext_level(ext_level),
    .port_pin_in(port_pin_in));
  // ==========================================
  // clock, timeout, high-time counter
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  always @(negedge clock) if (meas) hi_cnt += port_pin_out[msel];
  // ==========================================
  // helpers
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic int rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction
  task automatic cyc(bit we, bit re, logic [4:0] a, logic [7:0] d);
    wr_en <= we;
    rd_en <= re;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    cyc(1, 0, a, d);
  endtask
  task automatic rd(logic [4:0] a, output logic [7:0] d);
    cyc(0, 1, a, 8'h00);
    rd_en <= 0;
    @(negedge clock);
    d = rd_data;
    @(posedge clock);
  endtask
  // center mode: 2p ticks a period, count 0 seen once and 1..p-1 twice
  function automatic int exp_high(int p, int d, bit pol, bit ones, bit ctr);
    int n, lo;
    n = ctr ? 2 * p : p + 1;
    lo = ctr ? (d == 0 ? 0 : 2 * d - 1) : d;
    if (ones) return pol ? 0 : n;
    if (d >= p) return pol ? n : 0;
    return pol ? lo : n - lo;
  endfunction
  // one channel or joined lane run with settings written while disabled, then its high time measured
  task automatic trial(int c, bit cat, int p, int d, int f, bit sel, int s, bit pol, bit ones, bit ctr);
    int own, tick, per;
    logic [3:0] selb;
    own = cat ? c + 1 : c;
    selb = sel ? 4'(1 << own) : ~4'(1 << own);
    wr(A_EN, 8'h00);
    wr(A_MODE, {7'h00, ctr});
    wr(A_CLK, {cat && c == 2, cat && c == 0, 3'(f), 3'(f)});
    wr(A_SCL0, 8'(s));
    wr(A_SCL1, 8'(s));
    wr(A_POL, {selb, 4'(pol) << c});
    wr({G_PER, 2'(own)}, 8'(p));
    wr({G_DTY, 2'(own)}, ones ? 8'hff : 8'(d));
    if (cat) begin
      wr({G_PER, 2'(c)}, 8'h00);
      wr({G_DTY, 2'(c)}, 8'h00);
      wr({G_CNT, 2'(c + 1)}, 8'h00);
    end
    wr({G_CNT, 2'(c)}, 8'h00);
    wr(A_EN, 8'(1 << c));
    tick = (1 << f) * (sel ? 2 * (s + 1) : 1);
    per = (ctr ? 2 * p : p + 1) * tick;
    repeat (per + 4) cyc(0, 0, 5'h00, 8'h00);
    msel = c;
    hi_cnt = 0;
    meas = 1;
    repeat (2 * per) cyc(0, 0, 5'h00, 8'h00);
    meas = 0;
    chk("pwm high time", 16'(hi_cnt), 16'(2 * tick * exp_high(p, d, pol, ones, ctr)));
    if (cat) chk("odd pin of joined pair oe", 16'(port_pin_oe[c + 1]), 16'h0000);
    chk("enabled pin oe", 16'(port_pin_oe[c]), 16'h0001);
  endtask
  // ==========================================
  // main sequence
  initial begin
    int c, p;
    rst_n = 0;
    wr_en = 0;
    rd_en = 0;
    addr = 0;
    wr_data = 0;
    special_mode_flag = 0;
    ext_level = 0;
    meas = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    for (int a = 0; a < 8; a++) begin
      rd(5'(a), v);
      chk("reset value", v, 8'h00);
    end
    for (int a = 20; a < 28; a++) begin
      rd(5'(a), v);
      chk("period or duty reset", v, 8'hff);
    end
    wr(5'h1f, 8'h5a);
    rd(5'h1f, v);
    chk("unmapped index", v, 8'h00);
    for (int i = 0; i < 12; i++) begin
      c = rnd(4);
      w = 8'($random(seed));
      wr(c == 3 ? A_SCL1 : c == 2 ? A_SCL0 : c == 1 ? A_POL : A_CLK, w);
      rd(c == 3 ? A_SCL1 : c == 2 ? A_SCL0 : c == 1 ? A_POL : A_CLK, v);
      chk("register write then read", v, w);
    end
    rd(A_PRES, v);
    rd(A_PRES, w);
    chk("prescale held with all channels off", w, v);
    wr(A_PRES, 8'h55);
    rd(A_PRES, w);
    chk("prescale write outside special mode", w, v);
    special_mode_flag <= 1;
    wr(A_PRES, 8'hff);
    special_mode_flag <= 0;
    rd(A_PRES, w);
    chk("prescale write in special mode", w, 8'h7f);
    wr(A_EN, 8'h01);
    rd(A_PRES, v);
    rd(A_PRES, w);
    chk("prescale free running", w, {1'b0, 7'(v + 2)});
    for (int f = 0; f < 8; f++) trial(f % 4, 0, 2, 1, f, 0, 0, f[0], 0, 0);
    trial(1, 0, 2, 1, 0, 1, 255, 0, 0, 0);
    trial(0, 0, 3, 0, 0, 0, 0, 0, 0, 0);
    trial(3, 0, 3, 3, 0, 0, 0, 1, 0, 0);
    trial(2, 0, 4, 2, 1, 0, 0, 1, 1, 0);
    trial(1, 0, 5, 2, 0, 0, 0, 0, 0, 1);
    trial(2, 1, 6, 4, 1, 1, 1, 1, 0, 1);
    for (int i = 0; i < 20; i++) begin
      c = rnd(4);
      p = 2 + rnd(8);
      trial(c, rnd(2) && c % 2 == 0, p, rnd(p + 2), rnd(3), rnd(2), rnd(3), rnd(2),
            rnd(5) == 0 && c % 2 == 1, rnd(2));
    end
    // new period and duty written while running must wait for the rollover
    trial(0, 0, 100, 50, 0, 0, 0, 0, 0, 0);
    wr({G_CNT, 2'd0}, 8'h00);
    wr({G_PER, 2'd0}, 8'd60);
    wr({G_DTY, 2'd0}, 8'd10);
    hi_cnt = 0;
    meas = 1;
    repeat (30) cyc(0, 0, 5'h00, 8'h00);
    meas = 0;
    chk("duty held until rollover", 16'(hi_cnt), 16'h0000);
    repeat (100) cyc(0, 0, 5'h00, 8'h00);
    hi_cnt = 0;
    meas = 1;
    repeat (122) cyc(0, 0, 5'h00, 8'h00);
    meas = 0;
    chk("buffered values after rollover", 16'(hi_cnt), 16'(2 * exp_high(60, 10, 0, 0, 0)));
    dv = 4'($random(seed));
    pd = 4'($random(seed));
    ext_level = 4'($random(seed));
    wr(A_EN, 8'h00);
    wr(A_DIR, {4'h0, dv});
    wr(A_PORT, {4'h0, pd});
    cyc(0, 0, 5'h00, 8'h00);
    chk("pin oe from direction", port_pin_oe, dv);
    chk("port data on driven pins", port_pin_out & dv, pd & dv);
    rd(A_PORT, v);
    chk("pin read", v, {4'h0, (pd & dv) | (ext_level & ~dv)});
    wr(A_CLK, 8'h00);
    wr(A_EN, 8'h0f);
    cyc(0, 0, 5'h00, 8'h00);
    chk("enable takes pins", port_pin_oe, 4'hf);
    rd(A_DIR, v);
    chk("direction kept", v, {4'h0, dv});
    wr(A_EN, 8'h00);
    cyc(0, 0, 5'h00, 8'h00);
    chk("direction governs again", port_pin_oe, dv);
    stop_test();
  end
endmodule
